// ===== src/bsq_break_trace.sv
/*
 * Break sequencer, execution counter, saved-PC selection and four-entry
 * branch trace queue of a user break unit.
 * Assumes the channel comparators deliver per-cycle match pulses (masked
 * address/data compare done upstream) and the core reports retiring
 * instructions and branches, all synchronous to clk_in.
 */
// What this block does
// - With sequential mode set, break only when B matches after an earlier A.
// - In sequential mode a B match before any A match gives no break.
// - A and B matching in the same cycle gives no sequential break.
// - Clearing sequential mode discards a pending A match.
// - Sequence works on either bus and can combine with execution counting.
// - Counted sequence breaks on B match with count one after A.
// - Pre-execution break saves the matching instruction address, not executed.
// - Post-execution break saves the next instruction address after execution.
// - Address-only data break saves the next instruction address.
// - Data-value break may land two instructions late; saves next unexecuted.
// - Trace enabled stores branch source and destination for branches and interrupts.
// - Source is branch address, or accepting instruction address for exceptions.
// - Exception destination is the handler start address.
// - Trap-always is traced as an exception.
// - Queue holds four pairs; reads return the oldest first.
// - One read pointer shared; advances on destination read, or when a push into a full queue overwrites the oldest pair.
// - Toggling trace enable off then on invalidates all entries.
// - Address bits with mask one are excluded from comparison.
// - Fetch combined with write never matches, so never arms a sequence.
// - Count of five lets four executions run, breaks before fifth.
// - Data bits with mask one are ignored in comparison.
// - Each counted B match decrements the twelve-bit count by one while it is above one; zero never decrements.
// - Trace words hold address bits 27..0 and valid in bit 31.
// - Valid clears on read, on trace enable, or on reset.
`timescale 1ns/1ps
`include "bsq_defines.svh"

module bsq_break_trace (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Register port
  input wire logic [3:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  output logic [31:0] reg_rdata_out,
  // Comparator matches, local and internal bus
  input wire logic match_a_local_in,
  input wire logic match_a_int_in,
  input wire logic match_b_local_in,
  input wire logic match_b_int_in,
  input wire logic cond_a_fetch_write_in,
  input wire logic cond_b_fetch_write_in,
  // Core instruction stream
  input wire logic [31:0] match_pc_in,
  input wire logic [31:0] next_pc_in,
  input wire logic retire_in,
  input wire bsq_pkg::bsq_branch_t branch_in,
  // Break request
  output bsq_pkg::bsq_break_t break_out
);

  // ****************************************
  // Functions
  // ****************************************
  function automatic logic [31:0] trace_word(input logic v, input logic [31:0] a);
    trace_word = {v, 3'h0, a[`BSQ_ADDR_HI:0]};
  endfunction

  function automatic logic [1:0] ptr_inc(input logic [1:0] p);
    ptr_inc = p + 2'h1;
  endfunction

  // ****************************************
  // Control and count registers
  // ****************************************
  logic [31:0] ctrl_r;
  logic [`BSQ_COUNT_W-1:0] count_r;
  logic trace_en_prev_r;
  bsq_pkg::bsq_state_t seq_state_r;

  logic seq_mode;
  logic trace_en;
  logic use_ibus;
  logic cnt_en;
  logic wr_ctrl;
  logic hit_a;
  logic hit_b;
  logic trace_start;

  assign seq_mode = ctrl_r[`BSQ_CTRL_SEQ_BIT];
  assign trace_en = ctrl_r[`BSQ_CTRL_TRACE_BIT];
  assign use_ibus = ctrl_r[`BSQ_CTRL_IBUS_BIT];
  assign cnt_en = ctrl_r[`BSQ_CTRL_CNT_EN_BIT];
  assign wr_ctrl = reg_write_in && (reg_addr_in == `BSQ_OFF_CTRL);
  // Masking by address and data mask is in the comparators; here bus select
  assign hit_a = (use_ibus ? match_a_int_in : match_a_local_in)
    && !cond_a_fetch_write_in;
  assign hit_b = (use_ibus ? match_b_int_in : match_b_local_in)
    && !cond_b_fetch_write_in;
  assign trace_start = trace_en && !trace_en_prev_r;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ctrl_r <= `BSQ_CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_r <= reg_wdata_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      trace_en_prev_r <= 1'b0;
    end else begin
      trace_en_prev_r <= trace_en;
    end
  end

  // ****************************************
  // Sequencer and counter
  // ****************************************
  logic b_qualified;
  logic b_counted_ok;
  logic fire_a;
  logic fire_b;

  // In sequential mode B counts only once A is held from an earlier cycle
  assign b_qualified = hit_b && (!seq_mode ||
    (seq_state_r == bsq_pkg::BSQ_ST_ARMED && !hit_a));
  assign b_counted_ok = !cnt_en || (count_r == `BSQ_COUNT_ONE);
  assign fire_b = b_qualified && b_counted_ok;
  assign fire_a = hit_a && !seq_mode;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      seq_state_r <= bsq_pkg::BSQ_ST_IDLE;
    end else begin
      case (seq_state_r)
        bsq_pkg::BSQ_ST_IDLE: begin
          if (seq_mode && hit_a && !(wr_ctrl && !reg_wdata_in[`BSQ_CTRL_SEQ_BIT])) begin
            seq_state_r <= bsq_pkg::BSQ_ST_ARMED;
          end
        end
        bsq_pkg::BSQ_ST_ARMED: begin
          if (!seq_mode || (wr_ctrl && !reg_wdata_in[`BSQ_CTRL_SEQ_BIT])) begin
            seq_state_r <= bsq_pkg::BSQ_ST_IDLE;
          end else if (fire_b) begin
            seq_state_r <= bsq_pkg::BSQ_ST_IDLE;
          end
        end
        default: seq_state_r <= bsq_pkg::BSQ_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      count_r <= `BSQ_COUNT_RESET;
    end else if (reg_write_in && reg_addr_in == `BSQ_OFF_COUNT) begin
      count_r <= reg_wdata_in[`BSQ_COUNT_W-1:0];
    end else if (cnt_en && b_qualified && count_r != `BSQ_COUNT_ONE
        && count_r != `BSQ_COUNT_RESET) begin
      count_r <= count_r - `BSQ_COUNT_ONE;
    end
  end

  // ****************************************
  // Break request and saved PC
  // ****************************************
  // Data-value breaks wait for retirements; limitation: lands up to two late
  logic [1:0] dval_wait_r;
  logic dval_pend_r;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      dval_pend_r <= 1'b0;
      dval_wait_r <= 2'h0;
    end else if (fire_b && ctrl_r[`BSQ_CTRL_DATA_B_BIT] && !dval_pend_r) begin
      dval_pend_r <= 1'b1;
      dval_wait_r <= `BSQ_DATA_SLACK;
    end else if (dval_pend_r && retire_in) begin
      dval_wait_r <= dval_wait_r - 2'h1;
      if (dval_wait_r == 2'h1) begin
        dval_pend_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      break_out <= '0;
    end else begin
      break_out.valid <= 1'b0;
      if (fire_a) begin
        break_out.valid <= 1'b1;
        if (ctrl_r[`BSQ_CTRL_POST_A_BIT]) begin
          break_out.kind <= bsq_pkg::BSQ_KIND_POST;
          break_out.saved_pc <= next_pc_in;
        end else begin
          break_out.kind <= bsq_pkg::BSQ_KIND_PRE;
          break_out.saved_pc <= match_pc_in;
        end
      end else if (fire_b && !ctrl_r[`BSQ_CTRL_DATA_B_BIT]) begin
        break_out.valid <= 1'b1;
        if (ctrl_r[`BSQ_CTRL_POST_B_BIT]) begin
          break_out.kind <= bsq_pkg::BSQ_KIND_DADR;
          break_out.saved_pc <= next_pc_in;
        end else begin
          break_out.kind <= bsq_pkg::BSQ_KIND_PRE;
          break_out.saved_pc <= match_pc_in;
        end
      end else if (dval_pend_r && retire_in && dval_wait_r == 2'h1) begin
        break_out.valid <= 1'b1;
        break_out.kind <= bsq_pkg::BSQ_KIND_DVAL;
        break_out.saved_pc <= next_pc_in;
      end
    end
  end

  // ****************************************
  // Branch trace queue
  // ****************************************
  logic [31:0] src_q_r [`BSQ_DEPTH];
  logic [31:0] dst_q_r [`BSQ_DEPTH];
  logic [`BSQ_DEPTH-1:0] src_v_r;
  logic [`BSQ_DEPTH-1:0] dst_v_r;
  logic [1:0] wr_ptr_r;
  logic [1:0] rd_ptr_r;
  logic rd_src;
  logic rd_dst;
  logic push;

  assign rd_src = reg_read_in && reg_addr_in == `BSQ_OFF_SRC;
  assign rd_dst = reg_read_in && reg_addr_in == `BSQ_OFF_DST;
  // Exceptions and trap-always arrive with their accepting PC and handler
  assign push = trace_en && branch_in.valid;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wr_ptr_r <= 2'h0;
      rd_ptr_r <= 2'h0;
    end else if (trace_start) begin
      wr_ptr_r <= 2'h0;
      rd_ptr_r <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_r <= ptr_inc(wr_ptr_r);
      end
      // Full queue overwrites oldest, so the reader is pushed ahead
      if (rd_dst || (push && wr_ptr_r == rd_ptr_r && src_v_r[wr_ptr_r])) begin
        rd_ptr_r <= ptr_inc(rd_ptr_r);
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      src_v_r <= '0;
      dst_v_r <= '0;
    end else if (trace_start) begin
      src_v_r <= '0;
      dst_v_r <= '0;
    end else begin
      if (rd_src) begin
        src_v_r[rd_ptr_r] <= 1'b0;
      end
      if (rd_dst) begin
        dst_v_r[rd_ptr_r] <= 1'b0;
      end
      // Set wins over a same-cycle clear on the same slot
      if (push) begin
        src_v_r[wr_ptr_r] <= 1'b1;
        dst_v_r[wr_ptr_r] <= 1'b1;
      end
    end
  end

  // Address storage is not reset, as in the hardware it models
  always_ff @(posedge clk_in) begin
    if (push) begin
      src_q_r[wr_ptr_r] <= branch_in.source;
      dst_q_r[wr_ptr_r] <= branch_in.dest;
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      reg_rdata_out <= 32'h0000_0000;
    end else if (reg_read_in) begin
      case (reg_addr_in)
        `BSQ_OFF_CTRL: reg_rdata_out <= ctrl_r;
        `BSQ_OFF_COUNT: reg_rdata_out <= {20'h0_0000, count_r};
        `BSQ_OFF_SRC: reg_rdata_out <= trace_word(src_v_r[rd_ptr_r], src_q_r[rd_ptr_r]);
        `BSQ_OFF_DST: reg_rdata_out <= trace_word(dst_v_r[rd_ptr_r], dst_q_r[rd_ptr_r]);
        `BSQ_OFF_STATUS: reg_rdata_out <= {30'h0000_0000, seq_state_r};
        default: reg_rdata_out <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata_out <= 32'h0000_0000;
    end
  end

endmodule

// ===== src/bsq_defines.svh
/*
 * Constants of the break sequencer and branch trace block: register offsets,
 * control field positions, reset values and widths.
 * Assumes inclusion by bare name from the package and the design file.
 */
`ifndef BSQ_DEFINES_SVH
`define BSQ_DEFINES_SVH

// ****************************************
// Register offsets (word index on the plain port)
// ****************************************
`define BSQ_OFF_CTRL 4'h0
`define BSQ_OFF_COUNT 4'h1
`define BSQ_OFF_SRC 4'h2
`define BSQ_OFF_DST 4'h3
`define BSQ_OFF_STATUS 4'h4

// ****************************************
// Control register fields
// ****************************************
`define BSQ_CTRL_SEQ_BIT 0
`define BSQ_CTRL_TRACE_BIT 1
`define BSQ_CTRL_IBUS_BIT 2
`define BSQ_CTRL_CNT_EN_BIT 3
`define BSQ_CTRL_POST_A_BIT 4
`define BSQ_CTRL_POST_B_BIT 5
`define BSQ_CTRL_DATA_B_BIT 6
`define BSQ_CTRL_RESET 32'h0000_0000

// ****************************************
// Widths and counts
// ****************************************
`define BSQ_COUNT_W 12
`define BSQ_COUNT_ONE 12'h001
`define BSQ_COUNT_RESET 12'h000
`define BSQ_ADDR_HI 27
`define BSQ_VALID_BIT 31
`define BSQ_DEPTH 4
`define BSQ_DATA_SLACK 2'h2
`endif

// ===== src/bsq_pkg.sv
/*
 * Types of the break sequencer and branch trace block.
 * Assumes bsq_defines.svh is on the include path.
 */
`include "bsq_defines.svh"

package bsq_pkg;

  // Break kinds, one-hot
  typedef enum logic [3:0] {
    BSQ_KIND_PRE  = 4'h1,
    BSQ_KIND_POST = 4'h2,
    BSQ_KIND_DADR = 4'h4,
    BSQ_KIND_DVAL = 4'h8
  } bsq_kind_t;

  // Sequencer states, one-hot
  typedef enum logic [1:0] {
    BSQ_ST_IDLE  = 2'h1,
    BSQ_ST_ARMED = 2'h2
  } bsq_state_t;

  // Retired-branch event from the core
  typedef struct packed {
    logic valid;
    logic is_exception;
    logic [31:0] source;
    logic [31:0] dest;
  } bsq_branch_t;

  // Break request to the core
  typedef struct packed {
    logic valid;
    bsq_kind_t kind;
    logic [31:0] saved_pc;
  } bsq_break_t;

endpackage

// ===== test/bsq_asserts.sv
/* Checker of the break sequencer and trace read port, bound to bsq_break_trace.
   Assumes control fields as in bsq_defines.svh and one clock domain. */
`timescale 1ns/1ps
`include "bsq_defines.svh"
module bsq_asserts (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Register port
  input wire logic [3:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  input wire logic [31:0] reg_rdata_out,
  // Core side
  input wire logic match_a_local_in,
  input wire logic match_a_int_in,
  input wire logic match_b_local_in,
  input wire logic match_b_int_in,
  input wire logic cond_a_fetch_write_in,
  input wire logic cond_b_fetch_write_in,
  input wire logic [31:0] match_pc_in,
  input wire logic [31:0] next_pc_in,
  input wire bsq_pkg::bsq_break_t break_out
);
  // ****
  // Shadow of control and pending A
  // ****
  logic [6:0] ctrl_r;
  logic armed_r;
  wire logic ctl_wr = reg_write_in && reg_addr_in == `BSQ_OFF_CTRL;
  wire logic a_hit = (ctrl_r[2] ? match_a_int_in : match_a_local_in) && !cond_a_fetch_write_in;
  wire logic b_hit = (ctrl_r[2] ? match_b_int_in : match_b_local_in) && !cond_b_fetch_write_in;
  wire logic sq = ctrl_r[0] && !ctrl_r[3] && !ctrl_r[6];
  wire logic [31:0] seq_pc = ctrl_r[5] ? next_pc_in : match_pc_in;
  always_ff @(posedge clk_in) begin
    if (rst_in) ctrl_r <= 7'h00;
    else if (ctl_wr) ctrl_r <= reg_wdata_in[6:0];
  end
  always_ff @(posedge clk_in) begin
    if (rst_in || (ctl_wr && !reg_wdata_in[0])) armed_r <= 1'b0;
    // Count mode: count unseen here, so stay armed (only weakens AST_SEQ_NOB)
    else if (ctrl_r[0] && !ctrl_r[3] && armed_r && b_hit && !a_hit) armed_r <= 1'b0;
    else if (ctrl_r[0] && a_hit) armed_r <= 1'b1;
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // ****
  // Properties
  // ****
  AST_SEQ_FIRE: assert property (sq && armed_r && b_hit && !a_hit |=>
    break_out.valid && break_out.saved_pc == $past(seq_pc)) else $error("seq break wrong");
  AST_SEQ_NOB: assert property (ctrl_r[0] && !ctrl_r[6] && !armed_r && b_hit |=>
    !break_out.valid) else $error("break without prior A");
  AST_FW_NONE: assert property (!ctrl_r[6] && cond_a_fetch_write_in &&
    cond_b_fetch_write_in |=> !break_out.valid) else $error("fetch write matched");
  AST_PRE_PC: assert property (break_out.valid && break_out.kind == bsq_pkg::BSQ_KIND_PRE
    |-> break_out.saved_pc == $past(match_pc_in)) else $error("pre pc wrong");
  AST_POST_PC: assert property (break_out.valid &&
    break_out.kind == bsq_pkg::BSQ_KIND_POST
    |-> break_out.saved_pc == $past(next_pc_in)) else $error("post pc wrong");
  AST_DADR_PC: assert property (break_out.valid &&
    break_out.kind == bsq_pkg::BSQ_KIND_DADR
    |-> break_out.saved_pc == $past(next_pc_in)) else $error("data pc wrong");
  AST_TRACE_FMT: assert property (reg_read_in && reg_addr_in[3:1] == 3'h1 |=>
    reg_rdata_out[30:28] == 3'h0) else $error("trace word reserved bits");
  AST_RST_QUIET: assert property ($fell(rst_in) |-> !break_out.valid &&
    reg_rdata_out == 32'h0000_0000) else $error("outputs busy after reset");
  cover property (sq && armed_r && b_hit);
  cover property (break_out.valid && break_out.kind == bsq_pkg::BSQ_KIND_DVAL);
  cover property (reg_read_in && reg_addr_in == `BSQ_OFF_DST);
endmodule

bind bsq_break_trace bsq_asserts chk_u (.clk_in, .rst_in, .reg_addr_in, .reg_wdata_in,
  .reg_write_in, .reg_read_in, .reg_rdata_out, .match_a_local_in, .match_a_int_in,
  .match_b_local_in, .match_b_int_in, .cond_a_fetch_write_in, .cond_b_fetch_write_in,
  .match_pc_in, .next_pc_in, .break_out);

// ===== test/bsq_core_model.sv
/* Core stand-in: match pulses, retirements and branch events.
   Assumes its tasks are called from one bench process. */
`timescale 1ns/1ps
module bsq_core_model (
  // Clock
  input wire logic clk_in,
  // Matches {b_int, b_local, a_int, a_local}, pcs, events
  output logic [3:0] match_out,
  output logic [31:0] match_pc_out,
  output logic [31:0] next_pc_out,
  output logic retire_out,
  output bsq_pkg::bsq_branch_t branch_out
);
  // ****
  // Drive tasks
  // ****
  initial begin
    match_out = 4'h0;
    match_pc_out = 32'h0000_0000;
    next_pc_out = 32'h0000_0000;
    retire_out = 1'b0;
    branch_out = '0;
  end
  // Idle buses show inverted values so stale data cannot pass for fresh
  task automatic hit(input logic a, input logic b, input logic ib, input logic [31:0] pc);
    @(posedge clk_in);
    match_out <= ib ? {b, 1'b0, a, 1'b0} : {1'b0, b, 1'b0, a};
    match_pc_out <= pc;
    next_pc_out <= pc + 32'h0000_0002;
    @(posedge clk_in);
    match_out <= 4'h0;
    match_pc_out <= ~pc;
    next_pc_out <= ~pc;
  endtask
  task automatic ret(input logic [31:0] pc);
    @(posedge clk_in);
    retire_out <= 1'b1;
    next_pc_out <= pc;
    @(posedge clk_in);
    retire_out <= 1'b0;
    next_pc_out <= ~pc;
  endtask
  task automatic br(input logic ex, input logic [31:0] s, input logic [31:0] d);
    @(posedge clk_in);
    branch_out <= {1'b1, ex, s, d};
    @(posedge clk_in);
    branch_out <= {1'b0, ex, ~s, ~d};
  endtask
endmodule

// ===== test/tb_bsq_break_trace.sv
/* Self-checking bench of the break sequencer and branch trace.
   Assumes the core model and checker are compiled before it. */
`timescale 1ns/1ps
`include "bsq_defines.svh"
`define CHK(nm, got, exp) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) begin \
      mismatches++; \
      $display("[ERR] %s exp %h got %h", nm, (exp), (got)); \
    end \
  end
module tb_bsq_break_trace;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [3:0] reg_addr_in = 4'h0;
  logic [31:0] reg_wdata_in = 32'h0000_0000;
  logic reg_write_in = 1'b0;
  logic reg_read_in = 1'b0;
  logic fw_a = 1'b0;
  logic fw_b = 1'b0;
  logic [31:0] reg_rdata_out, q, mpc, npc;
  logic [3:0] m;
  logic ret;
  bsq_pkg::bsq_branch_t br;
  bsq_pkg::bsq_break_t brk, last;
  int mismatches = 0, num_checks = 0, nbrk = 0, cyc = 0, i, n0;
  bsq_break_trace dut_u (.clk_in, .rst_in, .reg_addr_in, .reg_wdata_in, .reg_write_in,
    .reg_read_in, .reg_rdata_out, .match_a_local_in(m[0]), .match_a_int_in(m[1]),
    .match_b_local_in(m[2]), .match_b_int_in(m[3]), .cond_a_fetch_write_in(fw_a),
    .cond_b_fetch_write_in(fw_b), .match_pc_in(mpc), .next_pc_in(npc), .retire_in(ret),
    .branch_in(br), .break_out(brk));
  bsq_core_model core_u (.clk_in, .match_out(m), .match_pc_out(mpc), .next_pc_out(npc),
    .retire_out(ret), .branch_out(br));
  always #25 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    if (brk.valid === 1'b1) begin
      nbrk++;
      last = brk;
    end
  end
  // ****
  // Access tasks
  // ****
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_write_in <= 1'b1;
    @(posedge clk_in);
    reg_write_in <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_read_in <= 1'b1;
    @(posedge clk_in);
    reg_read_in <= 1'b0;
    #1 d = reg_rdata_out;
  endtask
  task automatic hitc(input logic a, input logic b, input logic ib, input logic [31:0] pc,
    input int n);
    n0 = nbrk;
    core_u.hit(a, b, ib, pc);
    repeat (2) @(posedge clk_in);
    #1;
    `CHK("breaks", nbrk - n0, n)
  endtask
  function automatic logic [31:0] tw(input logic [31:0] a);
    return {1'b1, 3'h0, a[27:0]};
  endfunction
  task automatic rt(input logic [31:0] s, input logic [31:0] d);
    rd(`BSQ_OFF_SRC, q);
    `CHK("src", q, tw(s))
    rd(`BSQ_OFF_DST, q);
    `CHK("dst", q, tw(d))
  endtask
  task automatic test_done;
    if (mismatches == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 4000) begin
      mismatches++;
      test_done;
    end
  end
  // ****
  // Tests
  // ****
  initial begin
    repeat (12) @(posedge clk_in);
    rst_in <= 1'b0;
    rd(`BSQ_OFF_CTRL, q);
    `CHK("ctrl", q, `BSQ_CTRL_RESET)
    rd(4'h5, q);
    `CHK("unmapped", q, 32'h0000_0000)
    hitc(1, 0, 0, 32'h0000_0500, 1);
    `CHK("pre pc", last.saved_pc, 32'h0000_0500)
    `CHK("pre kind", last.kind, bsq_pkg::BSQ_KIND_PRE)
    wr(`BSQ_OFF_CTRL, 32'h0000_0010);
    hitc(1, 0, 0, 32'h0000_0404, 1);
    `CHK("post pc", last.saved_pc, 32'h0000_0406)
    `CHK("post kind", last.kind, bsq_pkg::BSQ_KIND_POST)
    wr(`BSQ_OFF_CTRL, 32'h0000_0020);
    hitc(0, 1, 0, 32'h0000_0600, 1);
    `CHK("daddr pc", last.saved_pc, 32'h0000_0602)
    `CHK("daddr kind", last.kind, bsq_pkg::BSQ_KIND_DADR)
    wr(`BSQ_OFF_CTRL, 32'h0000_0040);
    n0 = nbrk;
    core_u.hit(1'b0, 1'b1, 1'b0, 32'h0000_0700);
    core_u.ret(32'h0000_0702);
    core_u.ret(32'h0000_0704);
    repeat (2) @(posedge clk_in);
    #1;
    `CHK("dval n", nbrk - n0, 1)
    `CHK("dval pc", last.saved_pc, 32'h0000_0704)
    `CHK("dval kind", last.kind, bsq_pkg::BSQ_KIND_DVAL)
    wr(`BSQ_OFF_CTRL, 32'h0000_0000);
    fw_a <= 1'b1;
    fw_b <= 1'b1;
    hitc(1, 1, 0, 32'h0000_0800, 0);
    wr(`BSQ_OFF_CTRL, 32'h0000_0001);
    fw_b <= 1'b0;
    hitc(1, 0, 0, 32'h0000_0800, 0);
    hitc(0, 1, 0, 32'h0000_0802, 0);
    fw_a <= 1'b0;
    hitc(0, 1, 0, 32'h0000_0900, 0);
    hitc(1, 0, 0, 32'h0000_0a00, 0);
    rd(`BSQ_OFF_STATUS, q);
    `CHK("armed", q[1:0], 2'h2)
    hitc(0, 1, 0, 32'h0000_0b00, 1);
    `CHK("seq pc", last.saved_pc, 32'h0000_0b00)
    hitc(1, 1, 0, 32'h0000_0c00, 0);
    hitc(1, 1, 0, 32'h0000_0c02, 0);
    wr(`BSQ_OFF_CTRL, 32'h0000_0000);
    wr(`BSQ_OFF_CTRL, 32'h0000_0001);
    hitc(1, 0, 0, 32'h0000_0d00, 0);
    wr(`BSQ_OFF_CTRL, 32'h0000_0000);
    wr(`BSQ_OFF_CTRL, 32'h0000_0001);
    hitc(0, 1, 0, 32'h0000_0d02, 0);
    wr(`BSQ_OFF_CTRL, 32'h0000_0005);
    hitc(1, 0, 1, 32'h0000_0e00, 0);
    hitc(0, 1, 0, 32'h0000_0e04, 0);
    hitc(0, 1, 1, 32'h0000_0e02, 1);
    wr(`BSQ_OFF_COUNT, 32'h0000_0005);
    wr(`BSQ_OFF_CTRL, 32'h0000_0008);
    for (i = 0; i < 4; i++) hitc(0, 1, 0, 32'h0000_1000, 0);
    rd(`BSQ_OFF_COUNT, q);
    `CHK("count", q, 32'h0000_0001)
    hitc(0, 1, 0, 32'h0000_1000, 1);
    wr(`BSQ_OFF_CTRL, 32'h0000_0009);
    hitc(0, 1, 0, 32'h0000_1000, 0);
    hitc(1, 0, 0, 32'h0000_0f00, 0);
    hitc(0, 1, 0, 32'h0000_1000, 1);
    wr(`BSQ_OFF_CTRL, 32'h0000_0002);
    for (i = 0; i < 5; i++) begin
      core_u.br(i[0], 32'hf000_1000 + i, 32'h0000_2000 + i);
    end
    for (i = 1; i < 5; i++) rt(32'hf000_1000 + i, 32'h0000_2000 + i);
    core_u.br(1'b1, 32'h0000_3000, 32'h0000_4000);
    rd(`BSQ_OFF_SRC, q);
    rd(`BSQ_OFF_SRC, q);
    `CHK("src again", q, 32'h0000_3000)
    rd(`BSQ_OFF_DST, q);
    `CHK("dst", q, tw(32'h0000_4000))
    core_u.br(1'b0, 32'h0000_5000, 32'h0000_6000);
    wr(`BSQ_OFF_CTRL, 32'h0000_0000);
    wr(`BSQ_OFF_CTRL, 32'h0000_0002);
    rd(`BSQ_OFF_SRC, q);
    `CHK("flush", q[31], 1'b0)
    test_done;
  end
endmodule
